// ===== pkg/cdcd_pkg.sv
/*
 * constants for the character display command decoder: opcode patterns,
 * field positions, reset values, memory sizes and blink timing.
 * assumes a single 25 MHz clock and a host that strobes one transfer at a
 * time on a synchronous command port.
 */
package cdcd_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int BLINK_HALF_MS = 500;
	localparam int BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
	localparam int BLINK_CNT_W = 24;

	localparam int DISP_AW = 7;
	localparam int DISP_DEPTH = 128;
	localparam int GLYPH_AW = 6;
	localparam int GLYPH_DEPTH = 64;
	localparam logic [5:0] DISP_COLS_M1 = 6'h27;
	localparam logic [7:0] SPACE_CODE = 8'h20;
	localparam logic [7:0] GLYPH_RST = 8'h00;

	// opcode patterns, matched on the upper bits of a command byte
	localparam logic [0:0] OP_DISP_ADDR = 1'h1;
	localparam logic [1:0] OP_GLYPH_ADDR = 2'h1;
	localparam logic [2:0] OP_FUNC = 3'h1;
	localparam logic [3:0] OP_SHIFT = 4'h1;
	localparam logic [4:0] OP_DISP_CTRL = 5'h01;
	localparam logic [5:0] OP_ENTRY = 6'h01;
	localparam logic [6:0] OP_HOME = 7'h01;
	localparam logic [7:0] OP_CLEAR = 8'h01;

	// field positions
	localparam int BIT_DISP_EN = 2;
	localparam int BIT_CURSOR_EN = 1;
	localparam int BIT_BLINK_EN = 0;
	localparam int BIT_SHIFT_TGT = 3;
	localparam int BIT_SHIFT_DIR = 2;
	localparam int BIT_BUS_WIDTH = 4;
	localparam int BIT_LINES = 3;
	localparam int BIT_ENTRY_INC = 1;
	localparam int BIT_ENTRY_SHIFT = 0;

	// reset values
	localparam logic RST_ENTRY_INC = 1'b1;
	localparam logic RST_ENTRY_SHIFT = 1'b0;
	localparam logic RST_DISP_EN = 1'b0;
	localparam logic RST_CURSOR_EN = 1'b0;
	localparam logic RST_BLINK_EN = 1'b0;
	localparam logic RST_BUS_WIDTH = 1'b1;
	localparam logic RST_LINES = 1'b1;
	localparam logic [1:0] RST_LUMINANCE = 2'h0;
	localparam logic [6:0] RST_AC = 7'h00;
	localparam logic [5:0] RST_SHIFT = 6'h00;
endpackage

// ===== hdl/cdcd_mem.sv
/*
 * small register-file memory with one write port and a registered read of
 * the addressed word; clear loads every word with the reset value.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module cdcd_mem #(
	parameter int AW = 7,
	parameter int DEPTH = 128,
	parameter logic [7:0] RST_VAL = 8'h00
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_clear,
	input wire logic i_we,
	input wire logic [AW-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] word_reg [DEPTH];

	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : gen_word
			always_ff @(posedge i_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					word_reg[g] <= RST_VAL;
				end else if (i_clear) begin
					word_reg[g] <= RST_VAL;
				end else if (i_we && i_addr == AW'(g)) begin
					word_reg[g] <= i_wdata;
				end
			end
		end
	endgenerate

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= RST_VAL;
		end else begin
			o_rdata <= word_reg[i_addr];
		end
	end
endmodule

// ===== hdl/cdcd_top.sv
/*
 * command decoder and state keeper for a two-line character display.
 * takes instruction and data bytes from a synchronous host port, holds the
 * display settings, address counter and display shift, owns the display
 * and glyph memories and makes the blink timing.
 * assumes the host strobes no faster than one transfer every two clocks.
 */
`timescale 1ns/1ps
module cdcd_top #(
	parameter int unsigned P_BLINK_HALF_CYC = cdcd_pkg::BLINK_HALF_CYC
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_strobe,
	input wire logic i_register_select,
	input wire logic i_read_select,
	input wire logic [7:0] i_data_lines,
	output logic [7:0] o_data_lines,
	output logic o_data_valid,
	output logic o_display_enable,
	output logic o_cursor_enable,
	output logic o_blink_enable,
	output logic o_blink_cell_on,
	output logic o_bus_width_select,
	output logic o_line_count_select,
	output logic [1:0] o_luminance_field,
	output logic [cdcd_pkg::DISP_AW-1:0] o_address_counter,
	output logic o_glyph_target,
	output logic [5:0] o_shift_offset
);
	import cdcd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic nib_phase_reg;
	logic [3:0] nib_hi_reg;
	logic act;
	logic [7:0] byte_in;
	logic cmd_wr;
	logic dat_wr;
	logic ac_rd;
	logic dat_rd;
	logic is_disp_addr;
	logic is_glyph_addr;
	logic is_func;
	logic is_shift;
	logic is_disp_ctrl;
	logic is_entry;
	logic is_home;
	logic is_clear;
	logic [DISP_AW-1:0] ac_reg;
	logic [DISP_AW-1:0] ac_next;
	logic [DISP_AW-1:0] ac_inc;
	logic [DISP_AW-1:0] ac_dec;
	logic glyph_reg;
	logic glyph_next;
	logic entry_inc_reg;
	logic entry_shift_reg;
	logic disp_en_reg;
	logic cursor_en_reg;
	logic blink_en_reg;
	logic bus8_reg;
	logic lines_reg;
	logic [1:0] lum_reg;
	logic [5:0] shift_reg;
	logic [5:0] shift_next;
	logic shift_left;
	logic shift_right;
	logic [7:0] disp_q;
	logic [7:0] glyph_q;
	logic [7:0] read_val;
	logic [BLINK_CNT_W-1:0] blink_cnt_reg;
	logic blink_phase_reg;

	////////////////////////////////////////////////////////////////////////
	// host port: nibble pairing and byte assembly

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			nib_phase_reg <= 1'b0;
			nib_hi_reg <= 4'h0;
		end else if (bus8_reg) begin
			nib_phase_reg <= 1'b0;
		end else if (i_strobe) begin
			nib_phase_reg <= ~nib_phase_reg;
			if (!nib_phase_reg) begin
				nib_hi_reg <= i_data_lines[7:4];
			end
		end
	end

	// a transfer acts at once in 8-bit mode, on the second nibble otherwise
	assign act = i_strobe && (bus8_reg || nib_phase_reg);
	assign byte_in = bus8_reg ? i_data_lines
		: {nib_hi_reg, i_data_lines[7:4]};

	assign cmd_wr = act && !i_register_select && !i_read_select;
	assign dat_wr = act && i_register_select && !i_read_select;
	assign ac_rd = act && !i_register_select && i_read_select;
	assign dat_rd = act && i_register_select && i_read_select;

	////////////////////////////////////////////////////////////////////////
	// command decode, most specific pattern last in priority

	assign is_disp_addr = byte_in[7] == OP_DISP_ADDR;
	assign is_glyph_addr = byte_in[7:6] == OP_GLYPH_ADDR;
	assign is_func = byte_in[7:5] == OP_FUNC;
	assign is_shift = byte_in[7:4] == OP_SHIFT;
	assign is_disp_ctrl = byte_in[7:3] == OP_DISP_CTRL;
	assign is_entry = byte_in[7:2] == OP_ENTRY;
	assign is_home = byte_in[7:1] == OP_HOME;
	assign is_clear = byte_in == OP_CLEAR;

	////////////////////////////////////////////////////////////////////////
	// settings written by commands

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			disp_en_reg <= RST_DISP_EN;
			cursor_en_reg <= RST_CURSOR_EN;
			blink_en_reg <= RST_BLINK_EN;
		end else if (cmd_wr && is_disp_ctrl) begin
			disp_en_reg <= byte_in[BIT_DISP_EN];
			cursor_en_reg <= byte_in[BIT_CURSOR_EN];
			blink_en_reg <= byte_in[BIT_BLINK_EN];
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			bus8_reg <= RST_BUS_WIDTH;
			lines_reg <= RST_LINES;
			lum_reg <= RST_LUMINANCE;
		end else if (cmd_wr && is_func) begin
			bus8_reg <= byte_in[BIT_BUS_WIDTH];
			lines_reg <= byte_in[BIT_LINES];
			lum_reg <= byte_in[1:0];
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			entry_inc_reg <= RST_ENTRY_INC;
			entry_shift_reg <= RST_ENTRY_SHIFT;
		end else if (cmd_wr && is_entry) begin
			entry_inc_reg <= byte_in[BIT_ENTRY_INC];
			entry_shift_reg <= byte_in[BIT_ENTRY_SHIFT];
		end else if (cmd_wr && is_clear) begin
			entry_inc_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address counter and memory target

	assign ac_inc = ac_reg + 7'h01;
	assign ac_dec = ac_reg - 7'h01;

	always_comb begin
		ac_next = ac_reg;
		glyph_next = glyph_reg;
		if (cmd_wr) begin
			if (is_disp_addr) begin
				ac_next = byte_in[6:0];
				glyph_next = 1'b0;
			end else if (is_glyph_addr) begin
				ac_next = {1'b0, byte_in[5:0]};
				glyph_next = 1'b1;
			end else if (is_shift) begin
				ac_next = byte_in[BIT_SHIFT_DIR] ? ac_inc : ac_dec;
				glyph_next = 1'b0;
			end else if (is_clear || is_home) begin
				ac_next = RST_AC;
				glyph_next = 1'b0;
			end
		end else if (dat_wr || dat_rd) begin
			ac_next = entry_inc_reg ? ac_inc : ac_dec;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ac_reg <= RST_AC;
			glyph_reg <= 1'b0;
		end else begin
			ac_reg <= ac_next;
			glyph_reg <= glyph_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// display shift offset, modulo one line of the display memory

	assign shift_left = (cmd_wr && is_shift && byte_in[BIT_SHIFT_TGT]
		&& !byte_in[BIT_SHIFT_DIR])
		|| (dat_wr && !glyph_reg && entry_shift_reg
		&& entry_inc_reg);
	assign shift_right = (cmd_wr && is_shift && byte_in[BIT_SHIFT_TGT]
		&& byte_in[BIT_SHIFT_DIR])
		|| (dat_wr && !glyph_reg && entry_shift_reg
		&& !entry_inc_reg);

	always_comb begin
		shift_next = shift_reg;
		if (cmd_wr && (is_clear || is_home)) begin
			shift_next = RST_SHIFT;
		end else if (shift_left) begin
			shift_next = (shift_reg == DISP_COLS_M1) ? 6'h00
				: shift_reg + 6'h01;
		end else if (shift_right) begin
			shift_next = (shift_reg == 6'h00) ? DISP_COLS_M1
				: shift_reg - 6'h01;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			shift_reg <= RST_SHIFT;
		end else begin
			shift_reg <= shift_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// memories: only data writes and, for the display memory, clear touch them

	cdcd_mem #(
		.AW(DISP_AW),
		.DEPTH(DISP_DEPTH),
		.RST_VAL(SPACE_CODE)
	) u_disp_mem (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_clear(cmd_wr && is_clear),
		.i_we(dat_wr && !glyph_reg),
		.i_addr(ac_reg),
		.i_wdata(byte_in),
		.o_rdata(disp_q)
	);

	cdcd_mem #(
		.AW(GLYPH_AW),
		.DEPTH(GLYPH_DEPTH),
		.RST_VAL(GLYPH_RST)
	) u_glyph_mem (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_clear(1'b0),
		.i_we(dat_wr && glyph_reg),
		.i_addr(ac_reg[GLYPH_AW-1:0]),
		.i_wdata(byte_in),
		.o_rdata(glyph_q)
	);

	////////////////////////////////////////////////////////////////////////
	// read answers; busy indication is a constant zero

	assign read_val = i_register_select ? (glyph_reg ? glyph_q : disp_q)
		: {1'b0, ac_reg};

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_data_lines <= 8'h00;
			o_data_valid <= 1'b0;
		end else begin
			o_data_valid <= i_strobe && i_read_select;
			if (i_strobe && i_read_select) begin
				if (bus8_reg) begin
					o_data_lines <= read_val;
				end else if (!nib_phase_reg) begin
					o_data_lines <= {read_val[7:4], 4'h0};
				end else begin
					o_data_lines <= {read_val[3:0], 4'h0};
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// blink timing, free running

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			blink_cnt_reg <= '0;
			blink_phase_reg <= 1'b0;
		end else if (blink_cnt_reg
			== BLINK_CNT_W'(P_BLINK_HALF_CYC - 1)) begin
			blink_cnt_reg <= '0;
			blink_phase_reg <= ~blink_phase_reg;
		end else begin
			blink_cnt_reg <= blink_cnt_reg + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// display-facing outputs

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_display_enable <= RST_DISP_EN;
			o_cursor_enable <= RST_CURSOR_EN;
			o_blink_enable <= RST_BLINK_EN;
			o_blink_cell_on <= 1'b0;
			o_bus_width_select <= RST_BUS_WIDTH;
			o_line_count_select <= RST_LINES;
			o_luminance_field <= RST_LUMINANCE;
			o_address_counter <= RST_AC;
			o_glyph_target <= 1'b0;
			o_shift_offset <= RST_SHIFT;
		end else begin
			o_display_enable <= disp_en_reg;
			o_cursor_enable <= cursor_en_reg;
			o_blink_enable <= blink_en_reg;
			o_blink_cell_on <= blink_en_reg && blink_phase_reg;
			o_bus_width_select <= bus8_reg;
			o_line_count_select <= lines_reg;
			o_luminance_field <= lum_reg;
			o_address_counter <= ac_reg;
			o_glyph_target <= glyph_reg;
			o_shift_offset <= shift_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	chk_disp_ctrl_fields: assert property (
		cmd_wr && is_disp_ctrl |-> ##2 {o_display_enable, o_cursor_enable,
		o_blink_enable} == $past(byte_in[2:0], 2))
		else $error("display control fields not taken");

	chk_ctrl_keeps_ac: assert property (
		cmd_wr && (is_disp_ctrl || is_func) |=> $stable(ac_reg)
		&& $stable(glyph_reg))
		else $error("control command moved the counter");

	chk_shift_step_ac: assert property (
		cmd_wr && is_shift |=> ac_reg == ($past(byte_in[BIT_SHIFT_DIR])
		? $past(ac_inc) : $past(ac_dec)))
		else $error("shift command stepped counter wrongly");

	chk_shift_to_disp: assert property (
		cmd_wr && is_shift |=> !glyph_reg)
		else $error("shift left counter on glyph memory");

	chk_func_fields: assert property (
		cmd_wr && is_func |=> bus8_reg == $past(byte_in[BIT_BUS_WIDTH])
		&& lines_reg == $past(byte_in[BIT_LINES])
		&& lum_reg == $past(byte_in[1:0]))
		else $error("function set fields not taken");

	chk_glyph_load: assert property (
		cmd_wr && is_glyph_addr |=> glyph_reg
		&& ac_reg == {1'b0, $past(byte_in[5:0])})
		else $error("glyph address not loaded");

	chk_disp_load: assert property (
		cmd_wr && is_disp_addr |=> !glyph_reg
		&& ac_reg == $past(byte_in[6:0]))
		else $error("display address not loaded");

	chk_ac_read_val: assert property (
		ac_rd && bus8_reg |=> o_data_valid
		&& o_data_lines == {1'b0, $past(ac_reg)} && $stable(ac_reg))
		else $error("counter read answer wrong");

	chk_data_step: assert property (
		dat_wr || dat_rd |=> ac_reg == ($past(entry_inc_reg)
		? $past(ac_inc) : $past(ac_dec)))
		else $error("data access did not step counter");

	chk_nibble_wait: assert property (
		i_strobe && !bus8_reg && !nib_phase_reg |=> $stable(ac_reg)
		&& nib_phase_reg)
		else $error("first nibble acted on");

	chk_blink_off: assert property (
		!blink_en_reg |=> !o_blink_cell_on)
		else $error("blink shown while disabled");

	chk_blink_period: assert property (
		blink_cnt_reg < BLINK_CNT_W'(P_BLINK_HALF_CYC))
		else $error("blink divider overran");

	cov_disp_shift: cover property (cmd_wr && is_shift
		&& byte_in[BIT_SHIFT_TGT]);
	cov_glyph_write: cover property (dat_wr && glyph_reg);
	cov_nibble_read: cover property (dat_rd && !bus8_reg);
	cov_blink_toggle: cover property (blink_en_reg
		&& $changed(blink_phase_reg));
endmodule

// ===== sim/cdcd_host.sv
/*
 * host model for the command port: one strobe per transfer, two nibbles
 * per byte in 4-bit mode.
 * assumes the bench calls xfer only after reset has been released.
 */
`timescale 1ns/1ps
module cdcd_host (
	input wire logic i_clk,
	output logic o_strobe,
	output logic o_register_select,
	output logic o_read_select,
	output logic [7:0] o_data_lines
);
	initial begin
		o_strobe = 1'b0;
		o_register_select = 1'b0;
		o_read_select = 1'b0;
		o_data_lines = 8'h00;
	end
	// lines flip to the inverse once the strobe edge has passed
	task automatic put(input logic rs, input logic rd, input logic [7:0] d);
		@(posedge i_clk);
		#1;
		o_strobe = 1'b1;
		o_register_select = rs;
		o_read_select = rd;
		o_data_lines = d;
		@(posedge i_clk);
		#1;
		o_strobe = 1'b0;
		o_data_lines = ~d;
	endtask
	// no busy poll: next transfer after the least spacing plus a gap
	task automatic xfer(input logic rs, input logic rd, input logic [7:0] d,
		input bit four, input int gap);
		if (four) begin
			put(rs, rd, {d[7:4], ~d[3:0]});
			put(rs, rd, {d[3:0], d[7:4]});
		end else begin
			put(rs, rd, d);
		end
		repeat (gap) @(posedge i_clk);
	endtask
endmodule

// ===== sim/cdcd_top_tb.sv
/*
 * self-checking bench for the command decoder: host model drives, a
 * mirror of counter, shift and memories predicts, reads are queued.
 * assumes the design is built with a short blink half period.
 */
`timescale 1ns/1ps
module cdcd_top_tb;
	import cdcd_pkg::*;
	localparam int HALF = 8;
	logic clk, rstn, strobe, rs, rd, valid, den, cen, ben, bon, bw, lines;
	logic glyph;
	logic [7:0] din, dout, a;
	logic [1:0] lum;
	logic [6:0] ac, m_ac;
	logic [5:0] shift, m_sh;
	logic m_inc, m_es, m_tg;
	logic [7:0] dmem[128];
	logic [7:0] gmem[64];
	logic [7:0] exp_q[$];
	int err_count, samples_checked, cycles;
	bit four;

	cdcd_host i_cdcd_host (.i_clk(clk), .o_strobe(strobe),
		.o_register_select(rs), .o_read_select(rd), .o_data_lines(din));
	cdcd_top #(.P_BLINK_HALF_CYC(HALF)) i_cdcd_top (.i_clk(clk),
		.i_rstn(rstn), .i_strobe(strobe), .i_register_select(rs),
		.i_read_select(rd), .i_data_lines(din), .o_data_lines(dout),
		.o_data_valid(valid), .o_display_enable(den),
		.o_cursor_enable(cen), .o_blink_enable(ben), .o_blink_cell_on(bon),
		.o_bus_width_select(bw), .o_line_count_select(lines),
		.o_luminance_field(lum), .o_address_counter(ac),
		.o_glyph_target(glyph), .o_shift_offset(shift));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic conclude();
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic settle();
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic mv(input logic left);
		if (left)
			m_sh = (m_sh == 6'h27) ? 6'h00 : m_sh + 6'h01;
		else
			m_sh = (m_sh == 6'h00) ? 6'h27 : m_sh - 6'h01;
	endtask

	task automatic step();
		m_ac = m_inc ? m_ac + 7'h01 : m_ac - 7'h01;
	endtask

	task automatic cmd(input logic [7:0] d);
		i_cdcd_host.xfer(1'b0, 1'b0, d, four, $urandom_range(1));
		if (d[7]) begin
			m_ac = d[6:0];
			m_tg = 1'b0;
		end else if (d[7:6] == 2'b01) begin
			m_ac = {1'b0, d[5:0]};
			m_tg = 1'b1;
		end else if (d[7:2] == 6'h01) begin
			m_inc = d[1];
			m_es = d[0];
		end else if (d[7:4] == 4'h1) begin
			m_ac = d[2] ? m_ac + 7'h01 : m_ac - 7'h01;
			if (d[3]) mv(!d[2]);
			m_tg = 1'b0;
		end
	endtask

	task automatic expect_rd(input logic [7:0] e);
		if (four) begin
			exp_q.push_back({e[7:4], 4'h0});
			exp_q.push_back({e[3:0], 4'h0});
		end else begin
			exp_q.push_back(e);
		end
	endtask

	task automatic data_wr(input logic [7:0] v);
		i_cdcd_host.xfer(1'b1, 1'b0, v, four, $urandom_range(1));
		if (m_tg) begin
			gmem[m_ac[5:0]] = v;
		end else begin
			dmem[m_ac] = v;
			if (m_es) mv(m_inc);
		end
		step();
	endtask

	task automatic data_rd();
		expect_rd(m_tg ? gmem[m_ac[5:0]] : dmem[m_ac]);
		i_cdcd_host.xfer(1'b1, 1'b1, 8'h00, four, $urandom_range(1));
		step();
	endtask

	task automatic ac_rd();
		expect_rd({1'b0, m_ac});
		i_cdcd_host.xfer(1'b0, 1'b1, 8'h00, four, 0);
	endtask

	task automatic state_ok();
		settle();
		check("counter", {glyph, ac}, {m_tg, m_ac});
		check("shift", {2'b00, shift}, {2'b00, m_sh});
	endtask

	task automatic blink_count(input int exp);
		int n;
		n = 0;
		repeat (4 * HALF) begin
			@(posedge clk);
			#1;
			if (bon === 1'b1) n++;
		end
		check("blink cycles", 8'(n), 8'(exp));
	endtask

	task automatic block(input logic [7:0] set);
		logic [7:0] v;
		cmd(set);
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			data_wr(v);
		end
		state_ok();
		cmd(set);
		repeat (4) data_rd();
		state_ok();
	endtask

	// reads are compared in order as the valid pulses appear
	always @(negedge clk) begin
		if (valid === 1'b1) begin
			if (exp_q.size() == 0)
				check("spare read", 8'h00, 8'h01);
			else
				check("read data", dout, exp_q.pop_front());
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			check("run time", 8'h01, 8'h00);
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		rstn = 1'b0;
		four = 1'b0;
		{cycles, err_count, samples_checked} = '0;
		{m_ac, m_sh, m_es, m_tg, m_inc} = 16'h0001;
		foreach (dmem[i]) dmem[i] = 8'h20;
		void'($urandom(8218));
		repeat (8) @(posedge clk);
		#1;
		rstn = 1'b1;
		settle();
		check("settings", {den, cen, ben, bon, bw, lines, lum}, 8'h0c);
		state_ok();
		ac_rd();
		ac_rd();
		for (int i = 0; i < 3; i++) begin
			cmd(8'h80 | 8'($urandom_range(127)));
			data_rd();
		end
		$display("reset test done");
		for (int k = 0; k < 8; k++) begin
			cmd(8'h08 | 8'(k));
			state_ok();
			check("display ctl", {5'h0, den, cen, ben}, 8'(k));
		end
		blink_count(2 * HALF);
		cmd(8'h0e);
		blink_count(0);
		$display("display control test done");
		for (int k = 0; k < 8; k++) begin
			cmd(8'h30 | (8'(k[2]) << 3) | 8'(k[1:0])
				| 8'($urandom_range(1) << 2));
			state_ok();
			check("function", {bw, 4'h0, lines, lum}, {5'h10, 3'(k)});
		end
		$display("function set test done");
		a = 8'($urandom_range(127));
		block(8'h80 | a);
		block(8'h40 | 8'($urandom_range(63)));
		cmd(8'h04);
		block(8'h80 | 8'($urandom_range(127)));
		block(8'h40 | 8'($urandom_range(63)));
		$display("memory test done");
		for (int k = 0; k < 4; k++) begin
			cmd(8'h40 | 8'($urandom_range(63)));
			cmd(8'h10 | 8'(k << 2) | 8'($urandom_range(3)));
			state_ok();
		end
		cmd(8'h07);
		cmd(8'h80 | a);
		data_wr(8'($urandom));
		state_ok();
		cmd(8'h05);
		data_wr(8'($urandom));
		data_rd();
		state_ok();
		$display("shift test done");
		cmd(8'h28);
		four = 1'b1;
		i_cdcd_host.put(1'b0, 1'b0, 8'h8f);
		state_ok();
		i_cdcd_host.put(1'b0, 1'b0, 8'h5a);
		m_ac = 7'h05;
		state_ok();
		check("bus width", {7'h0, bw}, 8'h00);
		block(8'h80 | 8'($urandom_range(127)));
		ac_rd();
		cmd(8'h80 | a);
		repeat (2) data_rd();
		cmd(8'h38);
		four = 1'b0;
		settle();
		check("bus width", {7'h0, bw}, 8'h01);
		$display("nibble test done");
		repeat (4) @(posedge clk);
		check("pending reads", 8'(exp_q.size()), 8'h00);
		conclude();
	end
endmodule
